/* hdl/branch_unit_regs.svh */
// offsets, fields, codes and timing counts of the conditional short branch unit
// Notes on behaviour
// - taken branch adds sign-extended byte offset to instruction pointer
// - each branch is two bytes; target within about 127 bytes, same segment
// - overflow branch jumps when overflow set; 14 clocks taken, 4 not
// - no-overflow branch jumps when overflow clear; 14 taken, 4 not
// - carry-set / unsigned-below branch jumps on carry set; 14 or 4 clocks
// - carry-clear / not-below branch jumps on carry clear; 14 or 4 clocks
// - equal / zero branch jumps when zero flag set; 14 or 4 clocks
// - unequal / nonzero branch jumps when zero flag clear; 14 or 4 clocks
// - not-above branch jumps when carry or zero set; 14 or 4 clocks
// - above branch jumps when carry and zero both clear; 14 or 4 clocks
// - negative branch jumps when sign set; 14 or 4 clocks
// - positive branch jumps when sign clear; 14 or 4 clocks
// - even-parity branch jumps when parity set; 14 or 4 clocks
// - odd-parity branch jumps when parity clear; 14 or 4 clocks
// - signed less jumps when sign xor overflow set; 14 or 4 clocks
// - signed greater-or-equal jumps when sign xor overflow clear; 14 or 4
// - signed less-or-equal jumps when (sign xor overflow) or zero set
// - signed greater jumps when (sign xor overflow) or zero clear
// - branch not taken leaves pointer at the following instruction
// - loop-unequal decrements count; jumps if count nonzero and zero clear
// - loop-equal decrements count; jumps if count nonzero and zero set
// - plain loop decrements count; jumps if nonzero; 13 taken, 5 not
`ifndef BRANCH_UNIT_REGS_SVH
`define BRANCH_UNIT_REGS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFS_FLAGS 12'h000
`define OFS_IPTR 12'h004
`define OFS_COUNT 12'h008
`define OFS_EXEC 12'h00c
`define OFS_STATUS 12'h010

// ----------------------------------------------------------------
// flag register bit positions
// ----------------------------------------------------------------
`define FLG_CARRY 0
`define FLG_ZERO 1
`define FLG_SIGN 2
`define FLG_OFL 3
`define FLG_PARITY 4
`define FLG_W 5

// ----------------------------------------------------------------
// exec register fields, status fields
// ----------------------------------------------------------------
`define EXEC_OP_LSB 0
`define EXEC_OP_MSB 4
`define EXEC_DISP_LSB 8
`define EXEC_DISP_MSB 15
`define STS_BUSY 0
`define STS_TAKEN 1
`define STS_CLK_LSB 8
`define STS_CLK_MSB 15

// ----------------------------------------------------------------
// operation codes
// ----------------------------------------------------------------
`define OP_OFL 5'h00
`define OP_NO_OFL 5'h01
`define OP_CARRY_SET 5'h02
`define OP_CARRY_CLEAR 5'h03
`define OP_EQUAL 5'h04
`define OP_UNEQUAL 5'h05
`define OP_NOT_ABOVE 5'h06
`define OP_ABOVE 5'h07
`define OP_NEGATIVE 5'h08
`define OP_POSITIVE 5'h09
`define OP_EVEN_PAR 5'h0a
`define OP_ODD_PAR 5'h0b
`define OP_SIGNED_LESS 5'h0c
`define OP_SIGNED_GE 5'h0d
`define OP_SIGNED_LE 5'h0e
`define OP_SIGNED_GT 5'h0f
`define OP_LOOP_UNEQUAL 5'h10
`define OP_LOOP_EQUAL 5'h11
`define OP_LOOP_NONZERO 5'h12

// ----------------------------------------------------------------
// execution times in processor clocks, sizes, reset values
// ----------------------------------------------------------------
`define CLK_COND_TAKEN 8'h0e
`define CLK_COND_NOT 8'h04
`define CLK_LOOP_TAKEN 8'h0d
`define CLK_LOOP_NOT 8'h05
`define INSN_BYTES 16'h0002
`define RST_FLAGS 5'h00
`define RST_IPTR 16'h0000
`define RST_COUNT 16'h0000

`endif

/* hdl/branch_unit_pkg.sv */
// types of the conditional short branch unit
package branch_unit_pkg;

  typedef enum logic {
    EX_IDLE,
    EX_RUN
  } exec_st_t;

  typedef struct packed {
    exec_st_t ex_st;
    logic [7:0] remain;
    logic [4:0] flags;
    logic [15:0] ip;
    logic [15:0] count;
    logic taken;
    logic [7:0] last_clk;
    logic ack;
    logic slverr;
    logic [31:0] rdata;
  } unit_state_t;

endpackage

/* hdl/conditional_short_branch_unit.sv */
// condition test, pointer update and timing for short conditional branches
`timescale 1ns/1ns
`default_nettype none
`include "branch_unit_regs.svh"

module conditional_short_branch_unit (
  input wire logic CLK_SYS_I,
  input wire logic RESETN_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] sext8(input logic [7:0] d);
    sext8 = {{8{d[7]}}, d};
  endfunction

  function automatic logic is_loop(input logic [4:0] op);
    is_loop = (op == `OP_LOOP_UNEQUAL) ||
              (op == `OP_LOOP_EQUAL) ||
              (op == `OP_LOOP_NONZERO);
  endfunction

  function automatic logic op_valid(input logic [4:0] op);
    op_valid = (op <= `OP_LOOP_NONZERO);
  endfunction

  // cnt is the count after its decrement
  function automatic logic cond_met(
    input logic [4:0] op,
    input logic [4:0] f,
    input logic [15:0] cnt
  );
    logic c;
    logic z;
    logic s;
    logic v;
    logic p;
    logic nz;
    c = f[`FLG_CARRY];
    z = f[`FLG_ZERO];
    s = f[`FLG_SIGN];
    v = f[`FLG_OFL];
    p = f[`FLG_PARITY];
    nz = (cnt != 16'h0000);
    case (op)
      `OP_OFL: cond_met = v;
      `OP_NO_OFL: cond_met = !v;
      `OP_CARRY_SET: cond_met = c;
      `OP_CARRY_CLEAR: cond_met = !c;
      `OP_EQUAL: cond_met = z;
      `OP_UNEQUAL: cond_met = !z;
      `OP_NOT_ABOVE: cond_met = c | z;
      `OP_ABOVE: cond_met = !(c | z);
      `OP_NEGATIVE: cond_met = s;
      `OP_POSITIVE: cond_met = !s;
      `OP_EVEN_PAR: cond_met = p;
      `OP_ODD_PAR: cond_met = !p;
      `OP_SIGNED_LESS: cond_met = s ^ v;
      `OP_SIGNED_GE: cond_met = !(s ^ v);
      `OP_SIGNED_LE: cond_met = (s ^ v) | z;
      `OP_SIGNED_GT: cond_met = !((s ^ v) | z);
      `OP_LOOP_UNEQUAL: cond_met = nz & !z;
      `OP_LOOP_EQUAL: cond_met = nz & z;
      `OP_LOOP_NONZERO: cond_met = nz;
      default: cond_met = 1'b0;
    endcase
  endfunction

  function automatic logic [7:0] exec_clocks(
    input logic [4:0] op,
    input logic met
  );
    if (op == `OP_LOOP_NONZERO) begin
      exec_clocks = met ? `CLK_LOOP_TAKEN : `CLK_LOOP_NOT;
    end else if (is_loop(op)) begin
      exec_clocks = met ? `CLK_COND_TAKEN : `CLK_LOOP_NOT;
    end else begin
      exec_clocks = met ? `CLK_COND_TAKEN : `CLK_COND_NOT;
    end
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  branch_unit_pkg::unit_state_t st_reg;
  branch_unit_pkg::unit_state_t st_next;

  logic access;
  logic wr_take;
  logic busy;
  logic [4:0] op_w;
  logic [7:0] disp_w;
  logic [15:0] cnt_dec;
  logic met_w;
  logic launch;
  logic refuse;

  assign access = PSEL_I && PENABLE_I;
  // writes take effect only at the edge where the answer is given
  assign wr_take = access && st_reg.ack && PWRITE_I;
  assign busy = (st_reg.ex_st == branch_unit_pkg::EX_RUN);
  assign op_w = PWDATA_I[`EXEC_OP_MSB:`EXEC_OP_LSB];
  assign disp_w = PWDATA_I[`EXEC_DISP_MSB:`EXEC_DISP_LSB];
  assign cnt_dec = is_loop(op_w) ? st_reg.count - 16'h0001 : st_reg.count;
  assign met_w = cond_met(op_w, st_reg.flags, cnt_dec);

  // state is frozen during execution so the result stays consistent
  always_comb begin
    refuse = 1'b0;
    if (PWRITE_I) begin
      case (PADDR_I)
        `OFS_FLAGS: refuse = busy;
        `OFS_IPTR: refuse = busy;
        `OFS_COUNT: refuse = busy;
        `OFS_EXEC: refuse = busy || !op_valid(op_w);
        default: refuse = 1'b1;
      endcase
    end else begin
      case (PADDR_I)
        `OFS_FLAGS: refuse = 1'b0;
        `OFS_IPTR: refuse = 1'b0;
        `OFS_COUNT: refuse = 1'b0;
        `OFS_EXEC: refuse = 1'b0;
        `OFS_STATUS: refuse = 1'b0;
        default: refuse = 1'b1;
      endcase
    end
  end

  // the verdict latched at the first access edge decides: busy may end before the answer edge
  assign launch = wr_take && !st_reg.slverr && (PADDR_I == `OFS_EXEC);

  always_comb begin
    st_next = st_reg;
    // one wait state: read data is captured before the answer
    st_next.ack = access && !st_reg.ack;
    if (access && !st_reg.ack) begin
      st_next.slverr = refuse;
      st_next.rdata = 32'h0000_0000;
      if (!PWRITE_I) begin
        case (PADDR_I)
          `OFS_FLAGS: st_next.rdata[`FLG_W-1:0] = st_reg.flags;
          `OFS_IPTR: st_next.rdata[15:0] = st_reg.ip;
          `OFS_COUNT: st_next.rdata[15:0] = st_reg.count;
          `OFS_STATUS: begin
            st_next.rdata[`STS_BUSY] = busy;
            st_next.rdata[`STS_TAKEN] = st_reg.taken;
            st_next.rdata[`STS_CLK_MSB:`STS_CLK_LSB] = st_reg.last_clk;
          end
          default: st_next.rdata = 32'h0000_0000;
        endcase
      end
    end
    case (st_reg.ex_st)
      branch_unit_pkg::EX_IDLE: begin
        if (wr_take && !st_reg.slverr) begin
          case (PADDR_I)
            `OFS_FLAGS: st_next.flags = PWDATA_I[`FLG_W-1:0];
            `OFS_IPTR: st_next.ip = PWDATA_I[15:0];
            `OFS_COUNT: st_next.count = PWDATA_I[15:0];
            default: st_next.flags = st_reg.flags;
          endcase
        end
        if (launch) begin
          // flags are never written by execution
          st_next.count = cnt_dec;
          if (met_w) begin
            st_next.ip = st_reg.ip + `INSN_BYTES + sext8(disp_w);
          end else begin
            st_next.ip = st_reg.ip + `INSN_BYTES;
          end
          st_next.taken = met_w;
          st_next.last_clk = exec_clocks(op_w, met_w);
          st_next.remain = exec_clocks(op_w, met_w) - 8'h01;
          st_next.ex_st = branch_unit_pkg::EX_RUN;
        end
      end
      branch_unit_pkg::EX_RUN: begin
        // busy spans exactly the instruction's clock count
        if (st_reg.remain == 8'h00) begin
          st_next.ex_st = branch_unit_pkg::EX_IDLE;
        end else begin
          st_next.remain = st_reg.remain - 8'h01;
        end
      end
      default: st_next.ex_st = branch_unit_pkg::EX_IDLE;
    endcase
  end

  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      st_reg.ex_st <= branch_unit_pkg::EX_IDLE;
      st_reg.remain <= 8'h00;
      st_reg.flags <= `RST_FLAGS;
      st_reg.ip <= `RST_IPTR;
      st_reg.count <= `RST_COUNT;
      st_reg.taken <= 1'b0;
      st_reg.last_clk <= 8'h00;
      st_reg.ack <= 1'b0;
      st_reg.slverr <= 1'b0;
      st_reg.rdata <= 32'h0000_0000;
    end else begin
      st_reg <= st_next;
    end
  end

  assign PRDATA_O = st_reg.rdata;
  assign PREADY_O = st_reg.ack;
  assign PSLVERR_O = st_reg.ack && st_reg.slverr;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (!RESETN_I);

  AST_TAKEN_TARGET: assert property (
    launch && met_w |=>
      st_reg.ip == $past(st_reg.ip) + 16'h0002 + {{8{$past(disp_w[7])}}, $past(disp_w)})
    else $error("taken branch target wrong");

  AST_REACH: assert property (
    launch |=> (st_reg.ip - $past(st_reg.ip) + 16'h0080) < 16'h0102)
    else $error("branch target out of short reach");

  AST_OFL_COND: assert property (
    launch && op_w == `OP_OFL |-> met_w == st_reg.flags[`FLG_OFL])
    else $error("overflow branch decision wrong");

  AST_NOT_ABOVE_COND: assert property (
    launch && op_w == `OP_NOT_ABOVE |->
      met_w == (st_reg.flags[`FLG_CARRY] | st_reg.flags[`FLG_ZERO]))
    else $error("not-above branch decision wrong");

  AST_SIGNED_GT_COND: assert property (
    launch && op_w == `OP_SIGNED_GT |->
      met_w == !((st_reg.flags[`FLG_SIGN] ^ st_reg.flags[`FLG_OFL]) | st_reg.flags[`FLG_ZERO]))
    else $error("signed greater branch decision wrong");

  AST_COND_TAKEN_TIME: assert property (
    launch && met_w && !is_loop(op_w) |-> ##14 busy ##1 !busy)
    else $error("taken branch not 14 clocks");

  AST_COND_NOT_TIME: assert property (
    launch && !met_w && !is_loop(op_w) |-> ##4 busy ##1 !busy)
    else $error("untaken branch not 4 clocks");

  AST_NOT_TAKEN_IP: assert property (
    launch && !met_w |=> st_reg.ip == $past(st_reg.ip) + 16'h0002)
    else $error("untaken branch pointer wrong");

  AST_LOOP_DEC: assert property (
    launch && is_loop(op_w) |=> st_reg.count == $past(st_reg.count) - 16'h0001)
    else $error("loop count not decremented");

  AST_LOOP_EQ_COND: assert property (
    launch && op_w == `OP_LOOP_EQUAL |->
      met_w == (st_reg.count != 16'h0001 && st_reg.flags[`FLG_ZERO]))
    else $error("loop-equal decision wrong");

  AST_LOOP_NZ_TIME: assert property (
    launch && op_w == `OP_LOOP_NONZERO && met_w |-> ##13 busy ##1 !busy)
    else $error("plain loop taken not 13 clocks");

  AST_LOOP_NOT_TIME: assert property (
    launch && is_loop(op_w) && !met_w |-> ##5 busy ##1 !busy)
    else $error("loop exit not 5 clocks");

  AST_FLAGS_KEPT: assert property (
    busy |=> $stable(st_reg.flags))
    else $error("flags changed during execution");

endmodule
`default_nettype wire

/* tb/conditional_short_branch_unit_test.sv */
// self-checking bench of the conditional short branch unit
`timescale 1ns/1ns
`default_nettype none
`include "branch_unit_regs.svh"

module conditional_short_branch_unit_test;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [11:0] padr = 12'h000;
  logic [31:0] pwd = 32'h0;
  logic [31:0] prd;
  logic prdy;
  logic perr;
  logic [31:0] rd;
  logic err;
  int n_errors = 0;
  int cmp_count = 0;
  int cycles = 0;

  conditional_short_branch_unit u_conditional_short_branch_unit (
    .CLK_SYS_I(clk), .RESETN_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(padr), .PWDATA_I(pwd), .PRDATA_O(prd),
    .PREADY_O(prdy), .PSLVERR_O(perr));

  initial begin
    forever #4 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // hang guard, far above the roughly 4000 cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      final_report();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  // response fields are taken at the edge where pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= wr;
    padr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (prdy !== 1'b1);
    rd = prd;
    err = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask

  task automatic wait_idle();
    do begin
      apb(1'b0, `OFS_STATUS, 32'h0);
    end while (rd[0] !== 1'b0);
  endtask

  function automatic logic cond(input logic [4:0] op, input logic [4:0] f);
    logic c;
    logic z;
    logic s;
    logic o;
    c = f[`FLG_CARRY];
    z = f[`FLG_ZERO];
    s = f[`FLG_SIGN];
    o = f[`FLG_OFL];
    case (op)
      5'h00: cond = o;
      5'h01: cond = !o;
      5'h02: cond = c;
      5'h03: cond = !c;
      5'h04: cond = z;
      5'h05: cond = !z;
      5'h06: cond = c | z;
      5'h07: cond = !(c | z);
      5'h08: cond = s;
      5'h09: cond = !s;
      5'h0a: cond = f[`FLG_PARITY];
      5'h0b: cond = !f[`FLG_PARITY];
      5'h0c: cond = s ^ o;
      5'h0d: cond = !(s ^ o);
      5'h0e: cond = (s ^ o) | z;
      default: cond = !((s ^ o) | z);
    endcase
  endfunction

  task automatic run_op(input logic [4:0] op, input logic [4:0] fl, input logic [15:0] ip,
      input logic [15:0] cnt, input logic [7:0] dsp, input logic tk,
      input logic [15:0] cnt_x, input logic [7:0] clk_x);
    logic [15:0] ip_x;
    ip_x = ip + 16'h0002 + (tk ? {{8{dsp[7]}}, dsp} : 16'h0000);
    apb(1'b1, `OFS_FLAGS, {27'h0, fl});
    apb(1'b1, `OFS_IPTR, {16'h0, ip});
    apb(1'b1, `OFS_COUNT, {16'h0, cnt});
    apb(1'b1, `OFS_EXEC, {16'h0, dsp, 3'h0, op});
    chk("slverr exec", 32'h0, {31'h0, err});
    apb(1'b0, `OFS_STATUS, 32'h0);
    chk("busy", 32'h1, {31'h0, rd[0]});
    wait_idle();
    chk("status", {16'h0, clk_x, 6'h0, tk, 1'b0}, rd);
    rdchk("iptr", `OFS_IPTR, {16'h0, ip_x});
    rdchk("count", `OFS_COUNT, {16'h0, cnt_x});
    rdchk("flags", `OFS_FLAGS, {27'h0, fl});
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic test_reset_values();
    rdchk("flags rst", `OFS_FLAGS, 32'h0);
    rdchk("iptr rst", `OFS_IPTR, 32'h0);
    rdchk("count rst", `OFS_COUNT, 32'h0);
    rdchk("status rst", `OFS_STATUS, 32'h0);
  endtask

  // flag patterns chosen so every condition both holds and fails
  task automatic test_conditions();
    logic [4:0] ft [6] = '{5'h00, 5'h1f, 5'h09, 5'h04, 5'h0c, 5'h12};
    logic [7:0] dsp;
    logic tk;
    for (int op = 0; op < 16; op++) begin
      foreach (ft[i]) begin
        tk = cond(op[4:0], ft[i]);
        dsp = op[0] ? 8'h80 : 8'h7f;
        run_op(op[4:0], ft[i], 16'h1000 + 16'(op), 16'h0033, dsp, tk, 16'h0033,
               tk ? 8'h0e : 8'h04);
      end
    end
  endtask

  task automatic test_wrap();
    run_op(5'h04, 5'h02, 16'hfffe, 16'h0000, 8'h01, 1'b1, 16'h0000, 8'h0e);
  endtask

  task automatic test_loops();
    run_op(5'h10, 5'h00, 16'h0200, 16'h0002, 8'hfe, 1'b1, 16'h0001, 8'h0e);
    run_op(5'h10, 5'h02, 16'h0200, 16'h0002, 8'hfe, 1'b0, 16'h0001, 8'h05);
    run_op(5'h10, 5'h00, 16'h0200, 16'h0001, 8'hfe, 1'b0, 16'h0000, 8'h05);
    run_op(5'h11, 5'h02, 16'h0300, 16'h0002, 8'h80, 1'b1, 16'h0001, 8'h0e);
    run_op(5'h11, 5'h00, 16'h0300, 16'h0002, 8'h80, 1'b0, 16'h0001, 8'h05);
    run_op(5'h11, 5'h02, 16'h0300, 16'h0001, 8'h80, 1'b0, 16'h0000, 8'h05);
    run_op(5'h12, 5'h00, 16'h0400, 16'h0000, 8'h10, 1'b1, 16'hffff, 8'h0d);
    run_op(5'h12, 5'h02, 16'h0400, 16'h0001, 8'h10, 1'b0, 16'h0000, 8'h05);
    run_op(5'h12, 5'h02, 16'h0400, 16'h0003, 8'h10, 1'b1, 16'h0002, 8'h0d);
  endtask

  task automatic test_refusals();
    apb(1'b1, 12'h014, 32'h0000_00ff);
    chk("slverr unmapped wr", 32'h1, {31'h0, err});
    rdchk("unmapped rd", 12'h014, 32'h0);
    chk("slverr unmapped rd", 32'h1, {31'h0, err});
    apb(1'b1, `OFS_STATUS, 32'h0000_0003);
    chk("slverr status wr", 32'h1, {31'h0, err});
    rdchk("exec rd", `OFS_EXEC, 32'h0);
    apb(1'b1, `OFS_EXEC, 32'h0000_0013);
    chk("slverr bad op", 32'h1, {31'h0, err});
    rdchk("status idle", `OFS_STATUS, 32'h0000_0d02);
    apb(1'b1, `OFS_FLAGS, 32'h0000_0008);
    apb(1'b1, `OFS_EXEC, 32'h0000_0200);
    apb(1'b1, `OFS_FLAGS, 32'h0000_001f);
    chk("slverr busy wr", 32'h1, {31'h0, err});
    wait_idle();
    rdchk("flags kept", `OFS_FLAGS, 32'h0000_0008);
    // first access edge on the last busy cycle: refused although idle at the answer
    apb(1'b1, `OFS_EXEC, 32'h0000_0001);
    @(posedge clk);
    apb(1'b1, `OFS_FLAGS, 32'h0000_0001);
    chk("slverr busy end", 32'h1, {31'h0, err});
    wait_idle();
    rdchk("flags kept end", `OFS_FLAGS, 32'h0000_0008);
  endtask

  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    test_reset_values();
    test_conditions();
    test_wrap();
    test_loops();
    test_refusals();
    final_report();
  end
endmodule
`default_nettype wire
